//--- inc/synth_cfg_map.vh
`ifndef SYNTH_CFG_MAP_VH
`define SYNTH_CFG_MAP_VH
// ==========================================
// Register indexes
`define IDX_DIV_LOW 8'h00
`define IDX_DIV_HIGH 8'h01
`define IDX_COMMAND 8'hf0
// ==========================================
// Command codes, low nibble only
`define CMD_STEP_UP 4'h1
`define CMD_STEP_DOWN 4'h2
`define CMD_APPLY 4'h4
`define CMD_READBACK 4'h8
// ==========================================
// Slave address fixed part
`define SLAVE_ADDR_FIXED 5'h16
// ==========================================
// High register field positions
`define HI_FB_MSB 7
`define HI_FB_LSB 6
`define HI_OUTA_MSB 5
`define HI_OUTA_LSB 3
`define HI_OUTB_BIT 2
`define HI_REF_BIT 1
`define HI_LOCK_BIT 0
// ==========================================
// Edge detector reset level of the serial pins
`define LINE_IDLE 1'b1
`endif

//--- core/pin_sync.v
`timescale 1ns/10ps
// ==========================================
// Two-stage synchroniser, one per bit
module pin_sync #(
    parameter WIDTH = 1
) (
    input wire clk_sys,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta;
            reg stable;
            always @(posedge clk_sys) begin
                meta <= async_in[i];
                stable <= meta;
            end
            assign sync_out[i] = stable;
        end
    endgenerate
endmodule // pin_sync

//--- core/synth_divider_config_port.v
`timescale 1ns/10ps
`include "synth_cfg_map.vh"
module synth_divider_config_port (
    input wire clk_sys,
    input wire srst,
    input wire scl_in,
    input wire sda_in,
    output reg sda_oe,
    output reg sda_out,
    input wire addr_sel_hi,
    input wire addr_sel_lo,
    input wire pin_config_mode_n,
    input wire [9:0] pin_feedback_div,
    input wire [2:0] pin_output_a_divider,
    input wire pin_output_b_half_select,
    input wire pin_ref_half_select,
    input wire loop_locked,
    output reg [9:0] active_feedback_div,
    output reg [2:0] active_output_a_divider,
    output reg active_output_b_half_select,
    output reg active_ref_half_select
);
    // ==========================================
    // Input synchronisation
    wire [19:0] sync_bus;
    pin_sync #(.WIDTH(20)) u_sync (
        .clk_sys(clk_sys),
        .async_in({scl_in, sda_in, addr_sel_hi, addr_sel_lo,
                   pin_config_mode_n, pin_feedback_div,
                   pin_output_a_divider, pin_output_b_half_select,
                   pin_ref_half_select}),
        .sync_out(sync_bus)
    );
    wire scl_s = sync_bus[19];
    wire sda_s = sync_bus[18];
    wire [1:0] addr_sel_s = sync_bus[17:16];
    wire serial_mode = sync_bus[15];
    wire [14:0] pin_cfg = sync_bus[14:0];

    // ==========================================
    // Lock pin synchronisation
    wire lock_s;
    pin_sync #(.WIDTH(1)) u_lock_sync (
        .clk_sys(clk_sys),
        .async_in(loop_locked),
        .sync_out(lock_s)
    );

    // ==========================================
    // Bus line edge detection
    reg scl_d;
    reg sda_d;
    always @(posedge clk_sys) begin
        if (srst) begin
            scl_d <= `LINE_IDLE;
            sda_d <= `LINE_IDLE;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

    // ==========================================
    // Serial engine states
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_INDEX = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_ACK = 3'd4;
    localparam ST_SEND = 3'd5;
    localparam ST_MACK = 3'd6;

    reg [2:0] state;
    reg [2:0] after_ack;
    reg [7:0] shift;
    reg [2:0] bit_cnt;
    reg [7:0] index;
    reg read_sel;
    reg [7:0] div_low;
    reg [7:1] div_high;

    // ==========================================
    // Byte framing and read data
    wire [7:0] rx_byte = {shift[6:0], sda_s};
    wire [7:0] high_view = {div_high, lock_s};
    wire [7:0] tx_byte = read_sel ? high_view : div_low;

    // Byte just completed on this rising clock edge
    wire byte_done = scl_rise & (bit_cnt == 3'd7);
    wire wr_data = (state == ST_DATA) && byte_done;
    wire cmd_write = wr_data && (index == `IDX_COMMAND)
                     && serial_mode;
    wire [3:0] cmd_code = rx_byte[3:0];

    always @(posedge clk_sys) begin
        if (srst) begin
            state <= ST_IDLE;
            after_ack <= ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= 3'd0;
            index <= 8'h00;
            read_sel <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else if (start_cond) begin
            state <= ST_ADDR;
            bit_cnt <= 3'd0;
            sda_oe <= 1'b0;
        end else if (stop_cond) begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_ADDR, ST_INDEX, ST_DATA: begin
                    if (scl_rise) begin
                        shift <= rx_byte;
                        bit_cnt <= bit_cnt + 3'd1;
                    end
                    if (byte_done) begin
                        state <= ST_ACK;
                        if (state == ST_ADDR) begin
                            if (rx_byte[7:1] ==
                                {`SLAVE_ADDR_FIXED, addr_sel_s}) begin
                                after_ack <= rx_byte[0] ? ST_SEND
                                             : ST_INDEX;
                                read_sel <= 1'b0;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end else if (state == ST_INDEX) begin
                            index <= rx_byte;
                            after_ack <= ST_DATA;
                        end else begin
                            after_ack <= ST_INDEX;
                        end
                    end
                end
                ST_ACK: begin
                    // Drive ack low from the falling edge for one bit
                    if (scl_fall && !sda_oe) begin
                        sda_oe <= 1'b1;
                        sda_out <= 1'b0;
                    end else if (scl_fall && sda_oe) begin
                        sda_oe <= 1'b0;
                        bit_cnt <= 3'd0;
                        state <= after_ack;
                        if (after_ack == ST_SEND) begin
                            sda_oe <= ~tx_byte[7];
                            sda_out <= 1'b0;
                            shift <= {tx_byte[6:0], 1'b0};
                        end
                    end
                end
                ST_SEND: begin
                    // Open drain: only a zero is driven
                    if (scl_fall) begin
                        bit_cnt <= bit_cnt + 3'd1;
                        if (bit_cnt == 3'd7) begin
                            sda_oe <= 1'b0;
                            state <= ST_MACK;
                        end else begin
                            sda_oe <= ~shift[7];
                            shift <= {shift[6:0], 1'b0};
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state <= ST_IDLE;
                        end else begin
                            read_sel <= ~read_sel;
                        end
                    end else if (scl_fall) begin
                        bit_cnt <= 3'd0;
                        state <= ST_SEND;
                        sda_oe <= ~tx_byte[7];
                        shift <= {tx_byte[6:0], 1'b0};
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // Configuration registers and active dividers
    wire [14:0] active_cfg = {active_feedback_div, active_output_a_divider,
                              active_output_b_half_select,
                              active_ref_half_select};
    // Both registers in active divider order, lock bit left out
    wire [14:0] reg_image = {div_high[7:6], div_low, div_high[5:1]};
    wire [9:0] next_fb_up = active_feedback_div + 10'h001;
    wire [9:0] next_fb_down = active_feedback_div - 10'h001;
    reg serial_d;
    reg cfg_init;
    // Pins rule at reset release and all through pin mode
    wire pin_load = cfg_init || !serial_mode;
    // No serial data in the first cycle after leaving pin mode
    wire serial_write = wr_data && serial_d;

    // ==========================================
    // Mode tracking
    always @(posedge clk_sys) begin
        if (srst) begin
            serial_d <= 1'b0;
            cfg_init <= 1'b1;
        end else begin
            serial_d <= serial_mode;
            cfg_init <= 1'b0;
        end
    end

    // ==========================================
    // Configuration registers
    always @(posedge clk_sys) begin
        if (srst) begin
            div_low <= 8'h00;
            div_high <= 7'h00;
        end else if (pin_load) begin
            div_low <= pin_cfg[12:5];
            div_high <= {pin_cfg[14:13], pin_cfg[4:0]};
        end else if (serial_write) begin
            // Contents persist across transfers
            if (index == `IDX_DIV_LOW) begin
                div_low <= rx_byte;
            end else if (index == `IDX_DIV_HIGH) begin
                div_high <= rx_byte[7:1];
            end else if (cmd_write && (cmd_code == `CMD_READBACK)) begin
                div_low <= active_cfg[12:5];
                div_high <= {active_cfg[14:13], active_cfg[4:0]};
            end
        end
    end

    // ==========================================
    // Active dividers
    always @(posedge clk_sys) begin
        if (srst) begin
            active_feedback_div <= 10'h000;
            active_output_a_divider <= 3'h0;
            active_output_b_half_select <= 1'b0;
            active_ref_half_select <= 1'b0;
        end else if (pin_load) begin
            {active_feedback_div, active_output_a_divider,
             active_output_b_half_select,
             active_ref_half_select} <= pin_cfg;
        end else if (serial_write && cmd_write) begin
            // Register writes never reach here
            case (cmd_code)
                `CMD_STEP_UP: begin
                    active_feedback_div <= next_fb_up;
                end
                `CMD_STEP_DOWN: begin
                    active_feedback_div <= next_fb_down;
                end
                `CMD_APPLY: begin
                    {active_feedback_div, active_output_a_divider,
                     active_output_b_half_select,
                     active_ref_half_select} <= reg_image;
                end
                default: begin
                    // Readback and undefined codes keep the dividers
                    active_feedback_div <= active_feedback_div;
                end
            endcase
        end
    end
endmodule // synth_divider_config_port

//--- tb/synth_cfg_checker_assertions.sv
`timescale 1ns/10ps
// ====================
// Bus pin and divider checks
module synth_cfg_checker (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_oe,
    input wire logic sda_out,
    input wire logic pin_config_mode_n,
    input wire logic [9:0] pin_feedback_div,
    input wire logic [2:0] pin_output_a_divider,
    input wire logic [9:0] active_feedback_div,
    input wire logic [2:0] active_output_a_divider
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    sequence pin_mode_held;
        (!pin_config_mode_n && $stable(pin_feedback_div)
            && $stable(pin_output_a_divider)) [*6];
    endsequence
    sequence serial_low_held;
        (pin_config_mode_n && !scl_in) [*5];
    endsequence
    pin_follow_a: assert property (
        pin_mode_held |-> active_feedback_div == pin_feedback_div)
        else $error("feedback not following pins");
    pin_outa_a: assert property (
        pin_mode_held |-> active_output_a_divider == pin_output_a_divider)
        else $error("output divider not following pins");
    serial_quiet_a: assert property (
        serial_low_held |-> $stable(active_feedback_div)
            && $stable(active_output_a_divider))
        else $error("active divider moved outside a data bit");
    mode_leave_a: assert property (
        $rose(pin_config_mode_n) |=> $stable(active_feedback_div) [*8])
        else $error("divider changed on leaving pin mode");
    ack_low_a: assert property (
        $rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
        else $error("data line taken while clock high");
    release_low_a: assert property (
        $fell(sda_oe) |-> !scl_in)
        else $error("data line freed while clock high");
    open_drain_a: assert property (
        sda_oe |-> sda_out == 1'b0)
        else $error("data line driven high");
    sda_steady_a: assert property (
        scl_in [*5] |-> $stable(sda_oe))
        else $error("data line moved while clock high");
endmodule // synth_cfg_checker

//--- tb/i2c_host_model.sv
`timescale 1ns/10ps
// ====================
// Bus controller, pull-up on data line
module i2c_host_model (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Data moves only while clock low
    task automatic bit_io(input logic b, output logic seen);
        wait_n(3);
        sda_pull <= ~b;
        wait_n(10);
        scl <= 1'b1;
        wait_n(10);
        seen = sda_line;
        scl <= 1'b0;
    endtask
    task automatic start();
        wait_n(1);
        sda_pull <= 1'b1;
        wait_n(10);
        scl <= 1'b0;
    endtask
    task automatic stop();
        wait_n(3);
        sda_pull <= 1'b1;
        wait_n(10);
        scl <= 1'b1;
        wait_n(10);
        sda_pull <= 1'b0;
        wait_n(20);
    endtask
    // Address byte ends in direction bit
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~ack, s);
    endtask
endmodule // i2c_host_model

//--- tb/synth_divider_config_port_test.sv
`timescale 1ns/10ps
`include "synth_cfg_map.vh"
module synth_divider_config_port_test;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic scl;
    logic pull;
    logic sda_oe;
    logic sda_out;
    logic a_hi = 1'b0;
    logic a_lo = 1'b0;
    logic mode_n = 1'b1;
    logic lock = 1'b0;
    logic k;
    logic [14:0] pins = 15'h0000;
    logic [14:0] e_act;
    logic [14:0] e_cfg;
    wire [14:0] act;
    wire sda = ~pull & (~sda_oe | sda_out);
    int mismatches = 0;
    int n_checks = 0;
    logic [7:0] corner [4] = '{8'h94, 8'h31, 8'hc2, 8'h58};
    logic [3:0] cmds [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h0};
    logic [7:0] bad [2] = '{8'h04, 8'h80};
    always #12.5 clk_sys = ~clk_sys;
    i2c_host_model host_u (.clk_sys, .sda_line(sda), .scl, .sda_pull(pull));
    synth_divider_config_port dut_u (
        .clk_sys, .srst, .scl_in(scl), .sda_in(sda), .sda_oe, .sda_out,
        .addr_sel_hi(a_hi), .addr_sel_lo(a_lo), .pin_config_mode_n(mode_n),
        .pin_feedback_div(pins[14:5]), .pin_output_a_divider(pins[4:2]),
        .pin_output_b_half_select(pins[1]), .pin_ref_half_select(pins[0]),
        .loop_locked(lock), .active_feedback_div(act[14:5]),
        .active_output_a_divider(act[4:2]),
        .active_output_b_half_select(act[1]),
        .active_ref_half_select(act[0]));
    // ====================
    // Checking and closing
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function automatic logic [14:0] cfg_of(input logic [7:0] lo, hi);
        cfg_of = {hi[7:6], lo, hi[5:1]};
    endfunction
    // ====================
    // Transfers
    task automatic xfer(input logic [7:0] q[$]);
        host_u.start();
        host_u.send({`SLAVE_ADDR_FIXED, a_hi, a_lo, 1'b0}, k);
        check(k, 1'b1); // Address taken
        foreach (q[i]) begin
            host_u.send(q[i], k);
            check(k, 1'b1); // Byte taken
        end
        host_u.stop();
    endtask
    task automatic wregs(input logic [14:0] v);
        xfer('{`IDX_DIV_HIGH, {v[14:13], v[4:0], ~lock},
            `IDX_DIV_LOW, v[12:5]}); // High first
        if (mode_n)
            e_cfg = v;
    endtask
    task automatic cmd(input logic [7:0] c);
        xfer('{`IDX_COMMAND, c}); // Own transfer
        if (mode_n)
            case (c[3:0])
                `CMD_APPLY: e_act = e_cfg; // Load
                `CMD_READBACK: e_cfg = e_act; // Copy back
                `CMD_STEP_UP: e_act[14:5] += 10'h001; // Wraps
                `CMD_STEP_DOWN: e_act[14:5] -= 10'h001; // Wraps
                default: ; // Ignored
            endcase
    endtask
    task automatic rd();
        logic [7:0] lo;
        logic [7:0] hi;
        host_u.start();
        host_u.send({`SLAVE_ADDR_FIXED, a_hi, a_lo, 1'b1}, k);
        check(k, 1'b1); // Read taken
        host_u.recv(1'b1, lo);
        host_u.recv(1'b0, hi);
        host_u.stop();
        check(cfg_of(lo, hi), e_cfg); // Image
        check(hi[0], lock); // Lock mirror
        check(act, e_act); // Active set
    endtask
    // ====================
    // Tests
    initial begin
        void'($urandom(84898));
        {a_hi, a_lo, lock} <= 3'($urandom);
        pins <= 15'($urandom);
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        e_act = pins;
        e_cfg = pins;
        rd();
        $display("test reset done");
        wregs(15'($urandom));
        rd();
        wregs({10'h3ff, 5'($urandom)});
        $display("test registers done");
        for (int i = 0; i < 14; i++) begin
            // Config applied before stepping
            cmd(i < 4 ? corner[i] : {4'($urandom), cmds[$urandom % 6]});
            rd();
        end
        $display("test commands done");
        for (int i = 0; i < 2; i++) begin
            host_u.start();
            host_u.send({`SLAVE_ADDR_FIXED, a_hi, a_lo, 1'b0} ^ bad[i], k);
            check(k, 1'b0); // Foreign address
            host_u.stop();
        end
        rd();
        $display("test address done");
        pins <= 15'($urandom);
        mode_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        e_act = pins;
        e_cfg = pins;
        check(act, e_act); // Pins win
        wregs(~pins);
        cmd(8'h04);
        cmd(8'h08);
        lock <= ~lock;
        rd();
        mode_n <= 1'b1;
        repeat (10) @(posedge clk_sys);
        pins <= ~pins;
        repeat (10) @(posedge clk_sys);
        rd(); // Kept after leaving pin mode
        $display("test pin mode done");
        conclude();
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        conclude();
    end
endmodule // synth_divider_config_port_test
bind synth_divider_config_port synth_cfg_checker chk_u (
    .clk_sys, .srst, .scl_in, .sda_oe, .sda_out, .pin_config_mode_n,
    .pin_feedback_div, .pin_output_a_divider, .active_feedback_div,
    .active_output_a_divider);
